//--- logic/waiu_core.sv
`timescale 1ns/1ps
// Functional notes
// - Call pushes PC high, PC low, jumps
// - Memory operand: low word, high at +2
// - Call accepts all seven source modes
// - Call auto-increment adds four to pointer
// - Indexed/symbolic add sign-extended 16-bit offset
// - Indirect register: low at reg, high +2
// - Return pops PC low then high
// - Return leaves status bits 11:0 alone
// - Wide move changes no flags; source changes only by auto-increment
// - Move register to indexed/absolute memory, low first
// - Move auto-increment adds four to pointer
// - Wide clear writes zero, flags untouched
// - Compare subtracts, writes only flags
// - Compare N Z C V from subtraction
// - Subtract writes result, compare-style flags
// - Double-decrement subtracts two, Z/C per value
// - Double-increment adds two, V near max positive
// - Test sets N Z, C set, V clear
// - Mode bits in status changed only by register writes that target SR
module waiu_core #(
	parameter int REG_COUNT = 16 // General registers incl. PC, SP, SR
) (
	input wire logic clk, // 25 MHz master clock
	input wire logic rst_n, // Async reset, active low
	input wire logic start, // Request strobe from sequencer
	input wire waiu_pkg::waiu_req_t req, // Instruction fields, taken with start
	output logic ready, // Idle, a start will be taken
	output logic done, // One-cycle pulse, instruction retired
	input wire waiu_pkg::waiu_wr_t seqWr, // Sequencer register write, idle only
	input wire logic [3:0] rdIdx, // Register read select
	output logic [19:0] rdData, // Selected register, one cycle later
	output logic [19:0] pcOut, // Program counter
	output logic [19:0] spOut, // Stack pointer
	output logic [19:0] srOut, // Status register
	output waiu_pkg::waiu_mem_t mem, // Memory request, held until memAck
	input wire logic memAck, // Memory answer pulse
	input wire logic [15:0] memRdata // Read data, valid with memAck
);
	import waiu_pkg::*;

	generate
		if (REG_COUNT != WAIU_NREG) begin : g_bad_count
			$error("waiu_core: REG_COUNT must be 16");
		end
		// The fixed bit slices below assume these widths and flag places
		if (WAIU_AW != 20 || WAIU_DW != 16) begin : g_bad_width
			$error("waiu_core: built for 20-bit addresses and 16-bit words");
		end
		if (WAIU_SR_V >= WAIU_AW || WAIU_SR_N >= WAIU_AW) begin : g_bad_flag
			$error("waiu_core: flag positions lie outside the status register");
		end
	endgenerate

	typedef enum logic [3:0] {
		S_IDLE,
		S_RD_LO,
		S_RD_HI,
		S_PUSH_HI,
		S_PUSH_LO,
		S_WR_LO,
		S_WR_HI,
		S_POP_LO,
		S_POP_HI
	} waiu_state_t;

	waiu_state_t stateQ, stateD;
	waiu_req_t reqQ, reqD;
	waiu_mem_t memQ, memD;
	logic [19:0] tmpQ, tmpD;
	logic doneQ, doneD;
	logic [19:0] rfQ [REG_COUNT];
	logic [19:0] rdDataQ;
	waiu_wr_t wA, wB;
	logic flagWe;
	logic [3:0] flagD;

	logic [19:0] pc, sp, srcVal, dstVal, srcEa, dstEa, aluA, aluB, aluRes;
	logic [20:0] aluSum;
	logic aluCin;

	function automatic logic [19:0] sext16(input logic [15:0] v);
		return {{4{v[15]}}, v};
	endfunction

	assign pc = rfQ[WAIU_PC_IDX];
	assign sp = rfQ[WAIU_SP_IDX];

	// Operand selection for the request being offered or held
	waiu_req_t cur;
	assign cur = (stateQ == S_IDLE) ? req : reqQ;
	assign srcVal = (cur.mode == WAIU_M_IMM) ? cur.ext : rfQ[cur.src];
	assign dstVal = rfQ[cur.dst];

	always_comb begin
		case (cur.mode)
			WAIU_M_IDX: srcEa = rfQ[cur.src] + sext16(cur.ext[15:0]);
			WAIU_M_SYM: srcEa = pc + sext16(cur.ext[15:0]);
			WAIU_M_ABS: srcEa = cur.ext;
			default: srcEa = rfQ[cur.src];
		endcase
	end

	always_comb begin
		case (cur.mode)
			WAIU_M_IDX: dstEa = rfQ[cur.dst] + sext16(cur.ext[15:0]);
			WAIU_M_SYM: dstEa = pc + sext16(cur.ext[15:0]);
			default: dstEa = cur.ext;
		endcase
	end

	// One adder serves every flag-setting form; subtraction is A + ~B + 1
	always_comb begin
		aluA = dstVal;
		aluB = ~srcVal;
		aluCin = 1'b1;
		case (cur.op)
			WAIU_WIDE_DOUBLE_DECREMENT: aluB = ~WAIU_DECD_STEP;
			WAIU_WIDE_DOUBLE_INCREMENT: begin
				aluB = WAIU_INCD_STEP;
				aluCin = 1'b0;
			end
			WAIU_WIDE_TEST: aluB = ~WAIU_REG_RST;
			default: ;
		endcase
	end

	assign aluSum = {1'b0, aluA} + {1'b0, aluB} + {20'h00000, aluCin};
	assign aluRes = aluSum[19:0];

	always_comb begin
		stateD = stateQ;
		reqD = reqQ;
		memD = memQ;
		tmpD = tmpQ;
		doneD = 1'b0;
		wA = '0;
		wB = '0;
		flagWe = 1'b0;
		// Order is V N Z C; test always lands C=1 V=0 through the adder
		flagD = {(aluA[19] == aluB[19]) && (aluRes[19] != aluA[19]), aluRes[19],
			aluRes == 20'h00000, aluSum[20]};
		case (stateQ)
			S_IDLE: begin
				if (start) begin
					reqD = req;
					case (req.op)
						WAIU_LONG_CALL: begin
							if (req.mode == WAIU_M_REG || req.mode == WAIU_M_IMM) begin
								tmpD = srcVal;
								wA = '{1'b1, WAIU_SP_IDX, sp - WAIU_WORD_STEP};
								memD = '{1'b1, 1'b1, sp - WAIU_WORD_STEP, {WAIU_HI_PAD, pc[19:16]}};
								stateD = S_PUSH_HI;
							end else begin
								memD = '{1'b1, 1'b0, srcEa, 16'h0000};
								stateD = S_RD_LO;
							end
						end
						WAIU_LONG_RETURN: begin
							memD = '{1'b1, 1'b0, sp, 16'h0000};
							stateD = S_POP_LO;
						end
						WAIU_WIDE_MOVE: begin
							if (req.toMem) begin
								tmpD = rfQ[req.src];
								memD = '{1'b1, 1'b1, dstEa, rfQ[req.src][15:0]};
								stateD = S_WR_LO;
							end else if (req.mode == WAIU_M_REG || req.mode == WAIU_M_IMM) begin
								wA = '{1'b1, req.dst, srcVal};
								doneD = 1'b1;
							end else begin
								memD = '{1'b1, 1'b0, srcEa, 16'h0000};
								stateD = S_RD_LO;
							end
						end
						WAIU_WIDE_CLEAR: begin
							wA = '{1'b1, req.dst, WAIU_REG_RST};
							doneD = 1'b1;
						end
						WAIU_WIDE_COMPARE, WAIU_WIDE_TEST: begin
							flagWe = 1'b1;
							doneD = 1'b1;
						end
						WAIU_WIDE_SUBTRACT, WAIU_WIDE_DOUBLE_DECREMENT, WAIU_WIDE_DOUBLE_INCREMENT: begin
							wA = '{1'b1, req.dst, aluRes};
							flagWe = 1'b1;
							doneD = 1'b1;
						end
						// Undefined codes retire with no effect rather than corrupting a register
						default: begin
							doneD = 1'b1;
						end
					endcase
				end else if (seqWr.en) begin
					wA = seqWr;
				end
			end
			S_RD_LO: begin
				if (memAck) begin
					tmpD = {tmpQ[19:16], memRdata};
					memD.addr = memQ.addr + WAIU_WORD_STEP;
					stateD = S_RD_HI;
				end
			end
			S_RD_HI: begin
				if (memAck) begin
					if (reqQ.mode == WAIU_M_AINC) begin
						wB = '{1'b1, reqQ.src, rfQ[reqQ.src] + WAIU_AINC_STEP};
					end
					if (reqQ.op == WAIU_LONG_CALL) begin
						tmpD = {memRdata[3:0], tmpQ[15:0]};
						wA = '{1'b1, WAIU_SP_IDX, sp - WAIU_WORD_STEP};
						memD = '{1'b1, 1'b1, sp - WAIU_WORD_STEP, {WAIU_HI_PAD, pc[19:16]}};
						stateD = S_PUSH_HI;
					end else begin
						wA = '{1'b1, reqQ.dst, {memRdata[3:0], tmpQ[15:0]}};
						memD.req = 1'b0;
						doneD = 1'b1;
						stateD = S_IDLE;
					end
				end
			end
			S_PUSH_HI: begin
				if (memAck) begin
					wA = '{1'b1, WAIU_SP_IDX, sp - WAIU_WORD_STEP};
					memD = '{1'b1, 1'b1, sp - WAIU_WORD_STEP, pc[15:0]};
					stateD = S_PUSH_LO;
				end
			end
			S_PUSH_LO: begin
				if (memAck) begin
					wA = '{1'b1, WAIU_PC_IDX, tmpQ};
					memD.req = 1'b0;
					doneD = 1'b1;
					stateD = S_IDLE;
				end
			end
			S_WR_LO: begin
				if (memAck) begin
					memD = '{1'b1, 1'b1, memQ.addr + WAIU_WORD_STEP, {WAIU_HI_PAD, tmpQ[19:16]}};
					stateD = S_WR_HI;
				end
			end
			S_WR_HI: begin
				if (memAck) begin
					memD.req = 1'b0;
					doneD = 1'b1;
					stateD = S_IDLE;
				end
			end
			S_POP_LO: begin
				if (memAck) begin
					tmpD = {tmpQ[19:16], memRdata};
					wA = '{1'b1, WAIU_SP_IDX, sp + WAIU_WORD_STEP};
					memD.addr = sp + WAIU_WORD_STEP;
					stateD = S_POP_HI;
				end
			end
			S_POP_HI: begin
				if (memAck) begin
					// Upper twelve bits of the high stack word are discarded
					wA = '{1'b1, WAIU_SP_IDX, sp + WAIU_WORD_STEP};
					wB = '{1'b1, WAIU_PC_IDX, {memRdata[3:0], tmpQ[15:0]}};
					memD.req = 1'b0;
					doneD = 1'b1;
					stateD = S_IDLE;
				end
			end
			default: begin
				memD.req = 1'b0;
				stateD = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= S_IDLE;
			reqQ <= '0;
		end else begin
			stateQ <= stateD;
			reqQ <= reqD;
		end
	end

	// Memory request comes straight from flops, so the bus never sees glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memQ <= '0;
		end else begin
			memQ <= memD;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmpQ <= WAIU_REG_RST;
			doneQ <= 1'b0;
		end else begin
			tmpQ <= tmpD;
			doneQ <= doneD;
		end
	end

	// Port B is applied last so a pointer that is also a stack or PC target
	// ends with the later of the two values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				rfQ[i] <= WAIU_REG_RST;
			end
		end else begin
			if (wA.en) begin
				rfQ[wA.idx] <= wA.data;
			end
			if (wB.en) begin
				rfQ[wB.idx] <= wB.data;
			end
			if (flagWe) begin
				// Only C Z N V move; mode bits keep their value
				rfQ[WAIU_SR_IDX][WAIU_SR_C] <= flagD[0];
				rfQ[WAIU_SR_IDX][WAIU_SR_Z] <= flagD[1];
				rfQ[WAIU_SR_IDX][WAIU_SR_N] <= flagD[2];
				rfQ[WAIU_SR_IDX][WAIU_SR_V] <= flagD[3];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdDataQ <= WAIU_REG_RST;
		end else begin
			rdDataQ <= rfQ[rdIdx];
		end
	end

	assign ready = (stateQ == S_IDLE);
	assign done = doneQ;
	assign mem = memQ;
	assign rdData = rdDataQ;
	assign pcOut = rfQ[WAIU_PC_IDX];
	assign spOut = rfQ[WAIU_SP_IDX];
	assign srOut = rfQ[WAIU_SR_IDX];
endmodule // waiu_core

//--- pkg/waiu_pkg.sv
package waiu_pkg;
	localparam int WAIU_AW = 20;
	localparam int WAIU_DW = 16;
	localparam int WAIU_NREG = 16;
	localparam logic [3:0] WAIU_PC_IDX = 4'h0;
	localparam logic [3:0] WAIU_SP_IDX = 4'h1;
	localparam logic [3:0] WAIU_SR_IDX = 4'h2;
	localparam int WAIU_SR_C = 0;
	localparam int WAIU_SR_Z = 1;
	localparam int WAIU_SR_N = 2;
	localparam int WAIU_SR_V = 8;
	localparam logic [19:0] WAIU_WORD_STEP = 20'h00002;
	localparam logic [19:0] WAIU_AINC_STEP = 20'h00004;
	localparam logic [19:0] WAIU_DECD_STEP = 20'h00002;
	localparam logic [19:0] WAIU_INCD_STEP = 20'h00002;
	localparam logic [19:0] WAIU_REG_RST = 20'h00000;
	localparam logic [11:0] WAIU_HI_PAD = 12'h000;

	typedef enum logic [3:0] {
		WAIU_LONG_CALL,
		WAIU_LONG_RETURN,
		WAIU_WIDE_MOVE,
		WAIU_WIDE_CLEAR,
		WAIU_WIDE_COMPARE,
		WAIU_WIDE_SUBTRACT,
		WAIU_WIDE_DOUBLE_DECREMENT,
		WAIU_WIDE_DOUBLE_INCREMENT,
		WAIU_WIDE_TEST
	} waiu_op_t;

	typedef enum logic [2:0] {
		WAIU_M_REG,
		WAIU_M_IMM,
		WAIU_M_IDX,
		WAIU_M_SYM,
		WAIU_M_ABS,
		WAIU_M_IND,
		WAIU_M_AINC
	} waiu_mode_t;

	typedef struct packed {
		waiu_op_t op;
		waiu_mode_t mode;
		logic toMem;
		logic [3:0] src;
		logic [3:0] dst;
		logic [19:0] ext;
	} waiu_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [19:0] addr;
		logic [15:0] wdata;
	} waiu_mem_t;

	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [19:0] data;
	} waiu_wr_t;
endpackage

//--- tb/waiu_chk.sv
`timescale 1ns/1ps
module waiu_chk (
	input wire logic clk, // Master clock
	input wire logic rst_n, // Async reset
	input wire logic start, // Request strobe
	input wire waiu_pkg::waiu_req_t req, // Instruction fields
	input wire logic ready, // Idle
	input wire logic [19:0] pcOut, // Program counter
	input wire logic [19:0] spOut, // Stack pointer
	input wire logic [19:0] srOut, // Status
	input wire waiu_pkg::waiu_mem_t mem // Memory request
);
	import waiu_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic tk = start && ready;
	wire logic spOp = tk && req.dst == WAIU_SP_IDX;
	sequence pushHigh;
		mem.req && mem.we && mem.addr == $past(spOut) - 20'h2 && mem.wdata == {12'h0, $past(pcOut[19:16])};
	endsequence
	sequence popLow;
		mem.req && !mem.we && mem.addr == $past(spOut);
	endsequence
	a_call_push_high: assert property (tk && req.op == WAIU_LONG_CALL && req.mode == WAIU_M_IMM |=> pushHigh)
		else $error("call push wrong");
	a_return_pop_low: assert property (tk && req.op == WAIU_LONG_RETURN |=> popLow)
		else $error("return pop wrong");
	a_return_keeps_sr: assert property (tk && req.op == WAIU_LONG_RETURN |=> $stable(srOut) [*3])
		else $error("return altered status");
	a_clear_keeps_flags: assert property (tk && req.op == WAIU_WIDE_CLEAR && req.dst != WAIU_SR_IDX
		|=> srOut == $past(srOut))
		else $error("clear altered status");
	a_move_keeps_flags: assert property (tk && req.op == WAIU_WIDE_MOVE && req.dst != WAIU_SR_IDX
		|=> srOut == $past(srOut))
		else $error("move altered status");
	a_test_sets_c: assert property (tk && req.op == WAIU_WIDE_TEST |=> srOut[WAIU_SR_C] && !srOut[WAIU_SR_V])
		else $error("test flags wrong");
	a_decd_sp_flags: assert property (spOp && req.op == WAIU_WIDE_DOUBLE_DECREMENT
		|=> spOut == $past(spOut) - 20'h2 && srOut[WAIU_SR_Z] == ($past(spOut) == 20'h2)
		&& srOut[WAIU_SR_C] == ($past(spOut) > 20'h1))
		else $error("decrement wrong");
	a_incd_sp_flags: assert property (spOp && req.op == WAIU_WIDE_DOUBLE_INCREMENT
		|=> spOut == $past(spOut) + 20'h2
		&& srOut[WAIU_SR_V] == ($past(spOut) == 20'h7fffe || $past(spOut) == 20'h7ffff))
		else $error("increment wrong");
	a_mode_bits_kept: assert property (tk && req.dst != WAIU_SR_IDX |=> srOut[7:3] == $past(srOut[7:3]))
		else $error("mode bits changed");
endmodule // waiu_chk
bind waiu_core waiu_chk u_waiu_chk (.clk(clk), .rst_n(rst_n), .start(start), .req(req), .ready(ready),
	.pcOut(pcOut), .spOut(spOut), .srOut(srOut), .mem(mem));

//--- tb/waiu_mem_model.sv
`timescale 1ns/1ps
module waiu_mem_model (
	input wire logic clk, // Master clock
	input wire logic rst_n, // Async reset
	input wire waiu_pkg::waiu_mem_t mem, // Request from core
	output logic memAck, // Answer pulse
	output logic [15:0] memRdata // Read data
);
	import waiu_pkg::*;
	// Unwritten words read as unknown, so a stray read shows up downstream
	logic [15:0] m [0:1048575];
	logic [1:0] waitQ;
	// Random wait, so prompt and slow answers both occur
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memAck <= 1'b0;
			waitQ <= 2'h0;
			memRdata <= 16'h0;
		end else if (memAck) begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
			waitQ <= 2'($urandom_range(0, 3));
		end else if (mem.req && waitQ != 2'h0) begin
			waitQ <= waitQ - 2'h1;
		end else if (mem.req) begin
			memAck <= 1'b1;
			memRdata <= m[mem.addr];
			if (mem.we) begin
				m[mem.addr] <= mem.wdata;
			end
		end
	end
endmodule // waiu_mem_model

//--- tb/wide_address_instruction_unit_tb.sv
`timescale 1ns/1ps
module wide_address_instruction_unit_tb;
	import waiu_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	waiu_req_t rq = '0;
	waiu_wr_t seqWr = '0;
	logic [3:0] rdIdx = 4'h0;
	logic [3:0] d;
	logic ready, done, memAck;
	logic [19:0] rdData, pcOut, spOut, srOut, a, b, e, sr, pc;
	logic [15:0] memRdata;
	waiu_mem_t mem;
	waiu_op_t op;
	int bad_count = 0;
	int comparisons = 0;
	int i;
	waiu_op_t ops [7] = '{WAIU_WIDE_MOVE, WAIU_WIDE_CLEAR, WAIU_WIDE_COMPARE, WAIU_WIDE_SUBTRACT,
		WAIU_WIDE_DOUBLE_DECREMENT, WAIU_WIDE_DOUBLE_INCREMENT, WAIU_WIDE_TEST};
	logic [19:0] corner [6] = '{20'h0, 20'h1, 20'h2, 20'h7fffe, 20'h7ffff, 20'hfffff};
	initial forever #20 clk = ~clk;
	waiu_core u_waiu_core (.clk(clk), .rst_n(rst_n), .start(start), .req(rq), .ready(ready), .done(done),
		.seqWr(seqWr), .rdIdx(rdIdx), .rdData(rdData), .pcOut(pcOut), .spOut(spOut), .srOut(srOut),
		.mem(mem), .memAck(memAck), .memRdata(memRdata));
	waiu_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem(mem), .memAck(memAck), .memRdata(memRdata));
	task end_of_test;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [19:0] seen, input logic [19:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task setr(input logic [3:0] idx, input logic [19:0] v);
		@(negedge clk);
		seqWr = '{1'b1, idx, v};
		@(negedge clk);
		seqWr.en = 1'b0;
	endtask
	task rd(input logic [3:0] idx, input logic [19:0] exp);
		@(negedge clk);
		rdIdx = idx;
		@(negedge clk);
		chk(rdData, exp);
	endtask
	task run(input waiu_op_t o, input waiu_mode_t m, input logic t, input logic [3:0] s, dd, input logic [19:0] x);
		int n;
		@(negedge clk);
		start = 1'b1;
		rq = '{o, m, t, s, dd, x};
		@(negedge clk);
		start = 1'b0;
		for (n = 0; n < 100 && done !== 1'b1; n++)
			@(negedge clk);
		if (n == 100) begin
			bad_count++;
			end_of_test();
		end
	endtask
	// Subtraction as add of inverse plus one, so carry and overflow fall out alike
	function automatic logic [19:0] exp_of(input waiu_op_t o, input logic [19:0] s, dv, inout logic [19:0] st);
		logic [20:0] r;
		logic [19:0] t;
		logic inc;
		inc = (o == WAIU_WIDE_DOUBLE_INCREMENT);
		t = inc ? 20'h2 : ~((o == WAIU_WIDE_DOUBLE_DECREMENT) ? 20'h2 : (o == WAIU_WIDE_TEST) ? 20'h0 : s);
		r = {1'b0, dv} + {1'b0, t} + {20'h0, !inc};
		if (o == WAIU_WIDE_MOVE)
			return s;
		if (o == WAIU_WIDE_CLEAR)
			return 20'h0;
		st[WAIU_SR_C] = r[20];
		st[WAIU_SR_Z] = (r[19:0] == 20'h0);
		st[WAIU_SR_N] = r[19];
		st[WAIU_SR_V] = (dv[19] == t[19]) && (r[19] != dv[19]);
		// Flag forms stated per instruction take precedence over the generic adder view
		if (o == WAIU_WIDE_DOUBLE_DECREMENT) begin
			st[WAIU_SR_Z] = (dv == 20'h2);
			st[WAIU_SR_C] = (dv > 20'h1);
		end
		if (o == WAIU_WIDE_DOUBLE_INCREMENT)
			st[WAIU_SR_V] = (dv == 20'h7fffe || dv == 20'h7ffff);
		if (o == WAIU_WIDE_TEST) begin
			st[WAIU_SR_C] = 1'b1;
			st[WAIU_SR_V] = 1'b0;
		end
		return (o == WAIU_WIDE_COMPARE || o == WAIU_WIDE_TEST) ? dv : r[19:0];
	endfunction
	initial begin
		void'($urandom(32'h844c));
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (i = 0; i < 56; i++) begin
			op = ops[i % 7];
			a = 20'($urandom);
			b = (i < 42) ? corner[i / 7] : 20'($urandom);
			if (op == WAIU_WIDE_COMPARE && i[3])
				a = b;
			d = i[0] ? WAIU_SP_IDX : 4'h5;
			sr = 20'($urandom);
			setr(4'h4, a);
			setr(d, b);
			setr(WAIU_SR_IDX, sr);
			e = exp_of(op, a, b, sr);
			run(op, i[1] ? WAIU_M_IMM : WAIU_M_REG, 1'b0, 4'h4, d, a);
			rd(d, e);
			chk(srOut, sr);
			rd(4'h4, a);
		end
		pc = 20'($urandom);
		setr(WAIU_PC_IDX, pc);
		setr(WAIU_SP_IDX, 20'h00002);
		run(WAIU_LONG_CALL, WAIU_M_IMM, 1'b0, 4'h0, 4'h0, 20'habcde);
		chk(pcOut, 20'habcde);
		chk(spOut, 20'hffffe);
		chk({4'h0, u_mem.m[20'h00000]}, {16'h0, pc[19:16]});
		u_mem.m[20'h00000] = {12'ha5c, pc[19:16]};
		setr(WAIU_SR_IDX, sr);
		run(WAIU_LONG_RETURN, WAIU_M_REG, 1'b0, 4'h0, 4'h0, 20'h0);
		chk(pcOut, pc);
		chk(spOut, 20'h00002);
		chk(srOut, sr);
		u_mem.m[20'h01000] = 16'h1234;
		u_mem.m[20'h01002] = 16'hfff7;
		setr(4'h6, 20'h01000);
		run(WAIU_LONG_CALL, WAIU_M_AINC, 1'b0, 4'h6, 4'h0, 20'h0);
		chk(pcOut, 20'h71234);
		rd(4'h6, 20'h01004);
		setr(4'h8, a);
		run(WAIU_WIDE_MOVE, WAIU_M_ABS, 1'b1, 4'h8, 4'h0, 20'h02000);
		chk({4'h0, u_mem.m[20'h02000]}, {4'h0, a[15:0]});
		chk({4'h0, u_mem.m[20'h02002]}, {16'h0, a[19:16]});
		run(WAIU_LONG_CALL, WAIU_M_ABS, 1'b0, 4'h0, 4'h0, 20'h02000);
		chk(pcOut, a);
		setr(4'h9, 20'h01100);
		u_mem.m[20'h010f0] = 16'h5678;
		u_mem.m[20'h010f2] = 16'hfff3;
		run(WAIU_WIDE_MOVE, WAIU_M_IDX, 1'b0, 4'h9, 4'ha, 20'h0fff0);
		rd(4'ha, 20'h35678);
		u_mem.m[20'h01100] = 16'h9abc;
		u_mem.m[20'h01102] = 16'h000c;
		run(WAIU_WIDE_MOVE, WAIU_M_AINC, 1'b0, 4'h9, 4'hb, 20'h0);
		rd(4'hb, 20'hc9abc);
		rd(4'h9, 20'h01104);
		u_mem.m[20'h01104] = 16'h0246;
		u_mem.m[20'h01106] = 16'h0001;
		run(WAIU_WIDE_MOVE, WAIU_M_IND, 1'b0, 4'h9, 4'hc, 20'h0);
		rd(4'hc, 20'h10246);
		rd(4'h9, 20'h01104);
		end_of_test();
	end
endmodule // wide_address_instruction_unit_tb
